// ==== tlm_core.sv ====
`timescale 1ns/10ps
`default_nettype none

module tlm_core #(
  parameter int TW = 9,   // Temperature width
  parameter int CW = 8    // Calibration code width
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Register port
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  // Sensors and mode inputs
  input  wire logic [TW-1:0] die_temp,
  input  wire logic          analog_mode,
  input  wire logic          mode_pin_above_4v,
  input  wire logic          power_input_voltage_below_4v7,
  input  wire logic          track_sel_n,
  input  wire logic          cycle_start,
  input  wire logic          zero_cross,
  input  wire logic          il_positive,
  input  wire logic          vsns_below_ref,
  input  wire logic          vout_below_95pct,
  input  wire logic          ref_ramp_done,
  input  wire logic          vout_cmd_new,
  input  wire logic [CW-1:0] comp_code,
  input  wire logic          pwm_req,
  // Outputs
  output logic               conv_enable,
  output logic               feed_forward_en,
  output logic               high_side_drive,
  output logic               low_side_drive,
  output logic [CW-1:0]      cal_dac_code,
  output logic               adaptive_on_time_mode
);

  // ==========================================================================
  // Pin synchronisers
  localparam int SW = 10;
  logic [SW-1:0] pins_s;  // Synchronised pin levels

  tlm_sync #(.W(SW)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({mode_pin_above_4v, power_input_voltage_below_4v7, track_sel_n, cycle_start,
             zero_cross, il_positive, vsns_below_ref, vout_below_95pct,
             ref_ramp_done, vout_cmd_new}),
    .dout  (pins_s)
  );

  logic pin_4v, pin_lowpv, pin_trk_n, pin_cyc, pin_zc, pin_ilp;
  logic pin_below, pin_95, pin_rdone, pin_newv;
  assign {pin_4v, pin_lowpv, pin_trk_n, pin_cyc, pin_zc, pin_ilp,
          pin_below, pin_95, pin_rdone, pin_newv} = pins_s;

  // ==========================================================================
  // Registers and thermal state
  logic [1:0]    resp_q,  resp_d;    // Configured response
  logic          llen_q,  llen_d;    // Light-load command
  logic [TW-1:0] limit_q, limit_d;   // Trip threshold
  logic          inhib_q, inhib_d;   // Inhibit active
  logic          latch_q, latch_d;   // Latched shutdown
  logic [31:0]   rdata_q, rdata_d;   // Read data
  logic [TW-1:0] temp_q,  temp_d;    // Sampled temperature
  logic [1:0]    eff_resp;           // Response in force
  logic          over_trip, below_hyst;
  logic          cal_ok_q, cal_ok_d; // Calibration done
  logic [CW-1:0] cal_q,    cal_d;    // Captured error-amp code
  logic          aot_q;              // Light load active

  // Signed compare helper
  function automatic logic temp_gt(input logic [TW-1:0] a, input logic [TW-1:0] b);
    temp_gt = $signed(a) > $signed(b);
  endfunction

  // Thermal and register next values
  always_comb begin
    resp_d   = resp_q;
    llen_d   = llen_q;
    limit_d  = limit_q;
    temp_d   = die_temp;
    rdata_d  = 32'h00000000;
    eff_resp = analog_mode ? tlm_pkg::TLM_OT_INHIBIT : resp_q;
    over_trip  = temp_gt(temp_q, limit_q);
    below_hyst = !temp_gt(temp_q, TW'(limit_q - tlm_pkg::TEMP_HYST));
    inhib_d  = inhib_q;
    latch_d  = latch_q;
    // Write decode
    if (reg_wr) begin
      unique case (reg_addr)
        tlm_pkg::REG_CTRL: begin
          resp_d = reg_wdata[tlm_pkg::CTRL_RESP_LSB +: 2];
          llen_d = reg_wdata[tlm_pkg::CTRL_LL_BIT];
        end
        tlm_pkg::REG_OT_LIMIT: limit_d = reg_wdata[TW-1:0];
        tlm_pkg::REG_CLEAR: latch_d = 1'b0;
        default: ;
      endcase
    end
    // Inhibit with hysteresis
    if (eff_resp == tlm_pkg::TLM_OT_INHIBIT) begin
      if (over_trip) begin
        inhib_d = 1'b1;
      end else if (below_hyst) begin
        inhib_d = 1'b0;
      end
    end else begin
      inhib_d = 1'b0;
    end
    // Latch wins over clear
    if (eff_resp == tlm_pkg::TLM_OT_LATCH && over_trip) begin
      latch_d = 1'b1;
    end
    // Read decode
    if (reg_rd) begin
      unique case (reg_addr)
        tlm_pkg::REG_CTRL:     rdata_d = {29'h0, llen_q, resp_q};
        tlm_pkg::REG_OT_LIMIT: rdata_d = 32'(signed'(limit_q));
        tlm_pkg::REG_TEMP:     rdata_d = 32'(signed'(temp_q));
        tlm_pkg::REG_STATUS:   rdata_d = {27'h0, cal_ok_q, aot_q, latch_q,
                                          inhib_q, over_trip};
        tlm_pkg::REG_CAL:      rdata_d = 32'(cal_q);
        default:               rdata_d = 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // Light-load state
  tlm_pkg::tlm_state_t st_q, st_d;
  logic [3:0]    zc_q,   zc_d;     // Consecutive crossings
  logic [1:0]    lowc_q, lowc_d;   // Crossings below reference
  logic          zc_seen_q, zc_seen_d;
  logic          cyc_q;            // Previous cycle level
  logic          zc_prev_q;        // Previous crossing level
  logic [7:0]    ton_q,  ton_d;    // Pulse timer
  logic [7:0]    caldly_q, caldly_d;
  logic          ll_allow, cyc_edge, zc_edge, exit_req;

  localparam logic [7:0] TON = 8'(tlm_pkg::PULSE_CYCLES);
  localparam logic [7:0] CDL = 8'(tlm_pkg::CAL_CYCLES);

  // Light-load next values
  always_comb begin
    st_d      = st_q;
    zc_d      = zc_q;
    lowc_d    = lowc_q;
    zc_seen_d = zc_seen_q;
    ton_d     = ton_q;
    cal_ok_d  = cal_ok_q;
    cal_d     = cal_q;
    caldly_d  = caldly_q;
    cyc_edge  = pin_cyc && !cyc_q;
    zc_edge   = pin_zc && !zc_prev_q;
    ll_allow  = (analog_mode ? pin_4v : llen_q)
                && pin_trk_n
                && cal_ok_q;
    // Calibration after ramp completes
    if (pin_newv || !pin_rdone) begin
      cal_ok_d = 1'b0;
      caldly_d = 8'h00;
    end else if (!cal_ok_q) begin
      if (caldly_q == CDL) begin
        cal_d    = comp_code;
        cal_ok_d = 1'b1;
      end else begin
        caldly_d = caldly_q + 8'h01;
      end
    end
    exit_req = pin_95 || !ll_allow;
    unique case (st_q)
      tlm_pkg::TLM_PWM: begin
        lowc_d = 2'h0;
        if (zc_edge) zc_seen_d = 1'b1;
        if (cyc_edge) begin
          zc_seen_d = 1'b0;
          if (!zc_seen_q && !zc_edge) begin
            zc_d = 4'h0;
          end else if (zc_q == tlm_pkg::ZC_ENTER_COUNT - 4'h1) begin
            zc_d = 4'h0;
            // No entry while sagging, else a one-cycle glitch
            if (!exit_req) st_d = tlm_pkg::TLM_IDLE;
          end else begin
            zc_d = zc_q + 4'h1;
          end
        end
      end
      tlm_pkg::TLM_PULSE: begin
        if (ton_q == TON) begin
          st_d = tlm_pkg::TLM_LOW;
        end else begin
          ton_d = ton_q + 8'h01;
        end
      end
      tlm_pkg::TLM_LOW: begin
        if (zc_edge || !pin_ilp) begin
          st_d = tlm_pkg::TLM_IDLE;
          if (pin_below) begin
            if (lowc_q == tlm_pkg::ZC_EXIT_COUNT - 2'h1) begin
              st_d = tlm_pkg::TLM_PWM;
            end
            lowc_d = lowc_q + 2'h1;
          end else begin
            lowc_d = 2'h0;
          end
        end
      end
      tlm_pkg::TLM_IDLE: begin
        if (pin_below) begin
          st_d = pin_ilp ? tlm_pkg::TLM_WAIT : tlm_pkg::TLM_PULSE;
          ton_d = 8'h00;
        end
      end
      tlm_pkg::TLM_WAIT: begin
        if (!pin_ilp) begin
          st_d  = tlm_pkg::TLM_PULSE;
          ton_d = 8'h00;
        end
      end
      default: st_d = tlm_pkg::TLM_PWM;
    endcase
    if (st_q != tlm_pkg::TLM_PWM && exit_req) begin
      st_d = tlm_pkg::TLM_PWM;
      zc_d = 4'h0;
    end
  end

  // ==========================================================================
  // Register stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resp_q    <= tlm_pkg::CTRL_RESP_RESET;
      llen_q    <= 1'b0;
      limit_q   <= tlm_pkg::TEMP_TRIP_DEFAULT;
      inhib_q   <= 1'b0;
      latch_q   <= 1'b0;
      rdata_q   <= 32'h00000000;
      temp_q    <= '0;
      st_q      <= tlm_pkg::TLM_PWM;
      zc_q      <= 4'h0;
      lowc_q    <= 2'h0;
      zc_seen_q <= 1'b0;
      cyc_q     <= 1'b0;
      zc_prev_q <= 1'b0;
      ton_q     <= 8'h00;
      cal_ok_q  <= 1'b0;
      cal_q     <= '0;
      caldly_q  <= 8'h00;
      aot_q     <= 1'b0;
    end else begin
      resp_q    <= resp_d;
      llen_q    <= llen_d;
      limit_q   <= limit_d;
      inhib_q   <= inhib_d;
      latch_q   <= latch_d;
      rdata_q   <= rdata_d;
      temp_q    <= temp_d;
      st_q      <= st_d;
      zc_q      <= zc_d;
      lowc_q    <= lowc_d;
      zc_seen_q <= zc_seen_d;
      cyc_q     <= pin_cyc;
      zc_prev_q <= pin_zc;
      ton_q     <= ton_d;
      cal_ok_q  <= cal_ok_d;
      cal_q     <= cal_d;
      caldly_q  <= caldly_d;
      aot_q     <= (st_d != tlm_pkg::TLM_PWM);
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata             = rdata_q;
  assign conv_enable           = !inhib_q && !latch_q;
  assign feed_forward_en       = !pin_lowpv;
  assign cal_dac_code          = cal_q;
  assign adaptive_on_time_mode = aot_q;
  // Drives: PWM passes through, light load uses pulse/low phases
  assign high_side_drive = conv_enable &&
                           (aot_q ? (st_q == tlm_pkg::TLM_PULSE) : pwm_req);
  assign low_side_drive  = conv_enable &&
                           (aot_q ? (st_q == tlm_pkg::TLM_LOW) : !pwm_req);

endmodule

`default_nettype wire

// ==== tlm_pkg.sv ====
package tlm_pkg;

  // ==========================================================================
  // Temperature (1 degC per count, signed 9-bit)
  localparam logic [8:0] TEMP_TRIP_DEFAULT  = 9'h091;   // 145 degC
  localparam logic [8:0] TEMP_HYST          = 9'h019;   // 25 degC

  // ==========================================================================
  // Over-temperature responses
  typedef enum logic [1:0] {
    TLM_OT_IGNORE  = 2'h0,
    TLM_OT_INHIBIT = 2'h1,
    TLM_OT_LATCH   = 2'h2
  } tlm_ot_resp_t;

  // ==========================================================================
  // Register map (word offsets on the plain port)
  localparam logic [3:0] REG_CTRL     = 4'h0;  // [1:0] response, [2] light-load enable
  localparam logic [3:0] REG_OT_LIMIT = 4'h1;  // [8:0] trip threshold
  localparam logic [3:0] REG_TEMP     = 4'h2;  // [8:0] die temperature, read only
  localparam logic [3:0] REG_STATUS   = 4'h3;  // state flags, read only
  localparam logic [3:0] REG_CAL      = 4'h4;  // [7:0] calibration code, read only
  localparam logic [3:0] REG_CLEAR    = 4'h5;  // write: clear latched shutdown

  localparam int CTRL_RESP_LSB = 0;
  localparam int CTRL_LL_BIT   = 2;
  localparam logic [1:0] CTRL_RESP_RESET = 2'h1;

  // ==========================================================================
  // Light-load counts
  localparam logic [3:0] ZC_ENTER_COUNT = 4'h8;
  localparam logic [1:0] ZC_EXIT_COUNT  = 2'h3;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ      = 200;
  localparam int PULSE_NS     = 100;   // constant on-time pulse width
  localparam int PULSE_CYCLES = (PULSE_NS * CLK_MHZ) / 1000;
  localparam int CAL_DLY_NS   = 1000;  // delay after reference ramp
  localparam int CAL_CYCLES   = (CAL_DLY_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // Light-load state machine
  typedef enum logic [4:0] {
    TLM_PWM   = 5'h01,
    TLM_PULSE = 5'h02,
    TLM_LOW   = 5'h04,
    TLM_IDLE  = 5'h08,
    TLM_WAIT  = 5'h10
  } tlm_state_t;

endpackage

// ==== tlm_plant.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Power stage: 40-cycle switching period, inductor and output decay
module tlm_plant (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic light,
  input  wire logic heavy,
  input  wire logic high_side_drive,
  input  wire logic low_side_drive,
  output logic      cycle_start,
  output logic      pwm_req,
  output logic      zero_cross,
  output logic      il_positive,
  output logic      vsns_below_ref
);
  logic [5:0] ph_q;  // Switching phase
  logic [6:0] il_q;  // Inductor current
  logic [5:0] v_q;   // Cycles until output reaches reference
  // Current steps to a fixed level on high side, decays on low side
  always_ff @(posedge clk) begin
    ph_q <= (!rst_n || ph_q == 6'h27) ? 6'h00 : ph_q + 6'h01;
    zero_cross <= rst_n && low_side_drive && il_q == 7'h01;
    if (!rst_n) begin
      il_q <= 7'h00;
      v_q <= 6'h1E;
    end else if (high_side_drive) begin
      il_q <= light ? 7'h0C : 7'h7F;
      v_q <= 6'h1E;
    end else if (il_q != 7'h00) begin
      // Low side or body diode carries the decay
      il_q <= il_q - 7'h01;
    end else if (il_q == 7'h00 && v_q != 6'h00) begin
      v_q <= v_q - 6'h01;
    end
  end
  assign cycle_start = ph_q < 6'h04;
  assign pwm_req = cycle_start;
  assign il_positive = il_q != 7'h00;
  assign vsns_below_ref = heavy || v_q == 6'h00;
endmodule
`default_nettype wire

// ==== tlm_props.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Port checks of the light-load and thermal control
module tlm_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_input_voltage_below_4v7,
  input wire logic track_sel_n,
  input wire logic il_positive,
  input wire logic vout_below_95pct,
  input wire logic vout_cmd_new,
  input wire logic conv_enable,
  input wire logic feed_forward_en,
  input wire logic high_side_drive,
  input wire logic low_side_drive,
  input wire logic adaptive_on_time_mode
);
  localparam int PULSE_HI = tlm_pkg::PULSE_CYCLES + 1;  // High-side length
  logic [7:0] hi_cnt_q;  // High-side cycles in light load
  logic [7:0] hi_cnt_d;  // Next count
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Count running high-side pulse while in light load
  always_comb begin
    hi_cnt_d = (high_side_drive && adaptive_on_time_mode) ? hi_cnt_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk) begin
    hi_cnt_q <= rst_n ? hi_cnt_d : 8'h00;
  end
  // ========================================================================
  // Sequences
  sequence s_pulse_end;
    $fell(high_side_drive) && adaptive_on_time_mode && hi_cnt_q != 8'h00;
  endsequence
  sequence s_low_end;
    adaptive_on_time_mode && $past(adaptive_on_time_mode) && $fell(low_side_drive);
  endsequence
  // ========================================================================
  // Properties
  property p_off;
    !conv_enable |-> !high_side_drive && !low_side_drive;
  endproperty
  property p_ff;
    $stable(power_input_voltage_below_4v7) [*3] |-> feed_forward_en != power_input_voltage_below_4v7;
  endproperty
  property p_track;
    !track_sel_n [*4] |-> !adaptive_on_time_mode;
  endproperty
  property p_sag;
    vout_below_95pct [*4] |-> !adaptive_on_time_mode;
  endproperty
  property p_width;
    s_pulse_end |-> hi_cnt_q == PULSE_HI[7:0];
  endproperty
  property p_low_after;
    s_pulse_end |-> low_side_drive;
  endproperty
  property p_decay;
    adaptive_on_time_mode && il_positive [*4] |-> !$rose(high_side_drive);
  endproperty
  property p_newv;
    vout_cmd_new [*5] |-> !adaptive_on_time_mode;
  endproperty
  property p_idle;
    s_low_end |-> !high_side_drive;
  endproperty
  a_off: assert property (p_off) else $error("drive on while disabled");
  a_ff: assert property (p_ff) else $error("feed-forward mismatch");
  a_track: assert property (p_track) else $error("light load in tracking");
  a_sag: assert property (p_sag) else $error("light load at sag");
  a_width: assert property (p_width) else $error("pulse width wrong");
  a_low_after: assert property (p_low_after) else $error("no low drive");
  a_decay: assert property (p_decay) else $error("pulse before zero");
  a_newv: assert property (p_newv) else $error("light load in ramp");
  a_idle: assert property (p_idle) else $error("no idle gap");
endmodule
bind tlm_core tlm_props i_tlm_props (.clk, .rst_n, .power_input_voltage_below_4v7, .track_sel_n,
  .il_positive, .vout_below_95pct, .vout_cmd_new, .conv_enable, .feed_forward_en,
  .high_side_drive, .low_side_drive, .adaptive_on_time_mode);
`default_nettype wire

// ==== tlm_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// Two-flop synchroniser for a bus of pin levels
module tlm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;  // First stage, read only by second
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;  // Second stage
  logic [W-1:0] sync_d;

  // Next values
  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  // Registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;

endmodule

`default_nettype wire

// ==== tlm_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic [8:0]  die_temp = 9'h019;
  logic        analog_mode = 1'h0;
  logic        mode_pin_above_4v = 1'h0;
  logic        power_input_voltage_below_4v7 = 1'h0;
  logic        track_sel_n = 1'h1;
  logic        vout_below_95pct = 1'h0;
  logic        ref_ramp_done = 1'h0;
  logic        vout_cmd_new = 1'h0;
  logic [7:0]  comp_code = 8'h5A;
  logic        light = 1'h0;
  logic        heavy = 1'h0;
  logic        cycle_start, zero_cross, il_positive, vsns_below_ref, pwm_req;
  logic        conv_enable, feed_forward_en, high_side_drive, low_side_drive;
  logic        adaptive_on_time_mode;
  logic [7:0]  cal_dac_code;
  int          n_mismatch = 0;
  int          n_compared = 0;
  tlm_core i_tlm_core (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .die_temp, .analog_mode, .mode_pin_above_4v, .power_input_voltage_below_4v7, .track_sel_n,
    .cycle_start, .zero_cross, .il_positive, .vsns_below_ref, .vout_below_95pct,
    .ref_ramp_done, .vout_cmd_new, .comp_code, .pwm_req, .conv_enable, .feed_forward_en,
    .high_side_drive, .low_side_drive, .cal_dac_code, .adaptive_on_time_mode);
  tlm_plant i_tlm_plant (.clk, .rst_n, .light, .heavy, .high_side_drive,
    .low_side_drive, .cycle_start, .pwm_req, .zero_cross, .il_positive, .vsns_below_ref);
  // ========================================================================
  // Shared tasks
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rchk(string w, logic [3:0] a, logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 check(w, e, reg_rdata);
  endtask
  task automatic temp(logic [8:0] t, logic e, string w);
    @(posedge clk);
    die_temp <= t;
    repeat (4) @(posedge clk);
    #1 check(w, {31'h0, e}, {31'h0, conv_enable});
  endtask
  task automatic wait_aot(string w, logic e, int lim);
    #1;
    for (int i = 0; i < lim && adaptive_on_time_mode !== e; i++) begin
      @(posedge clk);
      #1;
    end
    check(w, {31'h0, e}, {31'h0, adaptive_on_time_mode});
  endtask
  // ========================================================================
  // Scenarios
  task automatic t_regs;
    rchk("ctrl", tlm_pkg::REG_CTRL, 32'h1);
    rchk("ot_limit", tlm_pkg::REG_OT_LIMIT, 32'h91);
    rchk("unmapped", 4'h9, 32'h0);
    temp(9'h1F6, 1'h1, "cold");
    rchk("temp", tlm_pkg::REG_TEMP, 32'hFFFFFFF6);
  endtask
  task automatic t_thermal;
    temp(9'h091, 1'h1, "at_trip");
    temp(9'h092, 1'h0, "over_trip");
    temp(9'h079, 1'h0, "in_hyst");
    temp(9'h078, 1'h1, "restart");
    wr(tlm_pkg::REG_OT_LIMIT, 32'h64);
    temp(9'h065, 1'h0, "new_limit");
    temp(9'h04B, 1'h1, "new_restart");
    wr(tlm_pkg::REG_OT_LIMIT, 32'h91);
    wr(tlm_pkg::REG_CTRL, 32'h2);
    temp(9'h092, 1'h0, "latch_trip");
    rchk("status", tlm_pkg::REG_STATUS, 32'h5);
    temp(9'h019, 1'h0, "latched");
    wr(tlm_pkg::REG_CLEAR, 32'h0);
    temp(9'h019, 1'h1, "cleared");
    wr(tlm_pkg::REG_CTRL, 32'h0);
    temp(9'h0C8, 1'h1, "ignore");
    @(posedge clk);
    analog_mode <= 1'h1;
    temp(9'h0C8, 1'h0, "analog");
    temp(9'h019, 1'h1, "analog_cool");
    @(posedge clk);
    analog_mode <= 1'h0;
  endtask
  task automatic t_ff;
    @(posedge clk);
    power_input_voltage_below_4v7 <= 1'h1;
    repeat (4) @(posedge clk);
    #1 check("ff_low", 32'h0, {31'h0, feed_forward_en});
    @(posedge clk);
    power_input_voltage_below_4v7 <= 1'h0;
    repeat (4) @(posedge clk);
    #1 check("ff_high", 32'h1, {31'h0, feed_forward_en});
  endtask
  task automatic t_exit(int k);
    @(posedge clk);
    case (k)
      0: heavy <= 1'h1;
      1: vout_below_95pct <= 1'h1;
      2: track_sel_n <= 1'h0;
      default: begin
        vout_cmd_new <= 1'h1;
        comp_code    <= 8'hA5;
      end
    endcase
    wait_aot("exit", 1'h0, 300);
    @(posedge clk);
    {heavy, vout_below_95pct, vout_cmd_new} <= 3'h0;
    track_sel_n <= 1'h1;
    wait_aot("reenter", 1'h1, 1500);
  endtask
  task automatic t_aot;
    @(posedge clk);
    ref_ramp_done <= 1'h1;
    repeat (250) @(posedge clk);
    #1 check("cal", 32'h5A, {24'h0, cal_dac_code});
    rchk("cal_reg", tlm_pkg::REG_CAL, 32'h5A);
    wr(tlm_pkg::REG_CTRL, 32'h5);
    light <= 1'h1;
    repeat (240) @(posedge clk);
    #1 check("early", 32'h0, {31'h0, adaptive_on_time_mode});
    wait_aot("enter", 1'h1, 600);
    for (int k = 0; k < 4; k++) t_exit(k);
    check("recal", 32'hA5, {24'h0, cal_dac_code});
    @(posedge clk);
    analog_mode <= 1'h1;
    wait_aot("pin_low", 1'h0, 50);
    @(posedge clk);
    mode_pin_above_4v <= 1'h1;
    wait_aot("pin_high", 1'h1, 600);
    @(posedge clk);
    analog_mode <= 1'h0;
    wr(tlm_pkg::REG_CTRL, 32'h1);
    wait_aot("cmd_off", 1'h0, 50);
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ========================================================================
  // Clock, watchdog and main sequence
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    t_regs;
    t_thermal;
    t_ff;
    t_aot;
    final_report;
  end
endmodule
`default_nettype wire
